// ### common/sgsc_defs.vh
/*
 Timing counts, analog widths and state encodings for the spindle gear stage
 sequencer. Assumes a 250 MHz scan clock; delay parameters arrive as counts of
 one millisecond ticks.
*/
`ifndef SGSC_DEFS_VH
`define SGSC_DEFS_VH
`define SGSC_CLK_MHZ 250
`define SGSC_TICK_US 1000
// One millisecond of the 250 MHz scan clock, sized to the prescaler width.
`define SGSC_TICK_CYCLES 18'h3d090
`define SGSC_TICK_W 18
`define SGSC_TIME_W 16
`define SGSC_ANA_W 12
`define SGSC_ANA_MAX 12'hfff
`define SGSC_ST_IDLE 3'h0
`define SGSC_ST_DLY1 3'h1
`define SGSC_ST_WAIT 3'h2
`define SGSC_ST_DLY2 3'h3
`define SGSC_ST_SWEX 3'h4
`define SGSC_ST_SWDL 3'h5
`endif

// ### hdl/sgsc_gear_stage_ctrl.v
/*
 Spindle gear stage sequencer: automatic gear shift with timed delays and an
 in-position wait, plus switching-mode gear commands driving four gear outputs.
 Assumes every command is a one-cycle pulse synchronous to clock_in, and that
 the gearbox drives one in-position input per stage. Delay inputs count ticks
 of TICK_CYCLES clocks; a count of zero ends after one cycle.
*/
// Summary of operation
// R1 - Auto shift runs only when enabled
// R2 - Shift only if requested gear differs
// R3 - Shift start outputs shift speed value
// R4 - After delay one, swap gear outputs
// R5 - Wait for requested stage in-position input
// R6 - Alarm when in-position check time expires
// R7 - After delay two output new gear speed
// R8 - Auto shift only under analog control
// R9 - Select while auto disabled raises alarm
// R10 - Select bit chooses analog or switching
// R11 - Estop bit may block speed codes
// R12 - Switching outputs idle after power-on
// R13 - Switching command latches matching output only
// R14 - Cancel command clears all gear outputs
// R15 - At most one gear output active
// R16 - Switching uses exec time and delay
// R17 - Hold bit keeps output after shift
// R18 - Gearbox returns one in-position per stage
// R19 - Speed scaled by active stage maximum
// R20 - Current gear register updated on completion
`timescale 1ns/1ps
`include "sgsc_defs.vh"
module sgsc_gear_stage_ctrl #(
    parameter [`SGSC_TICK_W-1:0] TICK_CYCLES = `SGSC_TICK_CYCLES
) (
    input wire clock_in,
    input wire resetn_in,
    input wire auto_shift_enable_in,
    input wire gear_output_hold_in,
    input wire speed_control_select_in,
    input wire estop_speed_code_block_in,
    input wire estop_in,
    input wire auto_gear_select_1_in,
    input wire auto_gear_select_2_in,
    input wire auto_gear_select_3_in,
    input wire auto_gear_select_4_in,
    input wire switch_gear_cmd_1_in,
    input wire switch_gear_cmd_2_in,
    input wire switch_gear_cmd_3_in,
    input wire switch_gear_cmd_4_in,
    input wire switch_gear_cancel_cmd_in,
    input wire speed_code_in,
    input wire [`SGSC_ANA_W-1:0] speed_request_in,
    input wire gear_in_position_1_in,
    input wire gear_in_position_2_in,
    input wire gear_in_position_3_in,
    input wire gear_in_position_4_in,
    input wire [`SGSC_ANA_W-1:0] shift_speed_value_in,
    input wire [`SGSC_TIME_W-1:0] shift_delay_one_in,
    input wire [`SGSC_TIME_W-1:0] shift_delay_two_in,
    input wire [`SGSC_TIME_W-1:0] shift_check_timeout_in,
    input wire [`SGSC_TIME_W-1:0] speed_code_exec_time_in,
    input wire [`SGSC_TIME_W-1:0] switch_gear_delay_in,
    input wire [`SGSC_ANA_W-1:0] gear_stage_out_1_max_speed_in,
    input wire [`SGSC_ANA_W-1:0] gear_stage_out_2_max_speed_in,
    input wire [`SGSC_ANA_W-1:0] gear_stage_out_3_max_speed_in,
    input wire [`SGSC_ANA_W-1:0] gear_stage_out_4_max_speed_in,
    output reg gear_stage_out_1,
    output reg gear_stage_out_2,
    output reg gear_stage_out_3,
    output reg gear_stage_out_4,
    output reg [`SGSC_ANA_W-1:0] analog_speed_out,
    output reg [2:0] current_gear_out,
    output reg shift_busy_out,
    output reg shift_timeout_alarm_out,
    output reg shift_disabled_alarm_out,
    output reg speed_code_done_out
);

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [3:0] gear_r;
    reg [3:0] gear_nxt;
    reg [2:0] target_r;
    reg [2:0] target_nxt;
    reg [`SGSC_TICK_W-1:0] tick_cnt_r;
    reg [`SGSC_TIME_W-1:0] time_cnt_r;
    reg [`SGSC_TIME_W-1:0] time_cnt_nxt;
    reg [`SGSC_ANA_W-1:0] ana_nxt;
    reg [2:0] cur_nxt;
    reg tmo_nxt;
    reg dis_nxt;
    reg done_nxt;

    wire tick = (tick_cnt_r == TICK_CYCLES - 1'b1);
    // Delay counters park at zero; every timed state tests this one expiry flag.
    wire time_up = (time_cnt_r == {`SGSC_TIME_W{1'b0}});
    wire [3:0] auto_sel = {auto_gear_select_4_in, auto_gear_select_3_in,
                           auto_gear_select_2_in, auto_gear_select_1_in};
    wire [3:0] sw_sel = {switch_gear_cmd_4_in, switch_gear_cmd_3_in,
                         switch_gear_cmd_2_in, switch_gear_cmd_1_in};
    wire [3:0] in_pos = {gear_in_position_4_in, gear_in_position_3_in,
                         gear_in_position_2_in, gear_in_position_1_in};
    // R11 estop code block
    wire codes_ok = !(estop_in && estop_speed_code_block_in);

    // Lowest set bit wins, so two simultaneous commands cannot light two outputs.
    function [2:0] sgsc_pick;
        input [3:0] sel;
        begin
            if (sel[0]) begin
                sgsc_pick = 3'h1;
            end else if (sel[1]) begin
                sgsc_pick = 3'h2;
            end else if (sel[2]) begin
                sgsc_pick = 3'h3;
            end else if (sel[3]) begin
                sgsc_pick = 3'h4;
            end else begin
                sgsc_pick = 3'h0;
            end
        end
    endfunction

    // R15 one-hot decode
    function [3:0] sgsc_onehot;
        input [2:0] g;
        begin
            case (g)
                3'h1: sgsc_onehot = 4'h1;
                3'h2: sgsc_onehot = 4'h2;
                3'h3: sgsc_onehot = 4'h4;
                3'h4: sgsc_onehot = 4'h8;
                default: sgsc_onehot = 4'h0;
            endcase
        end
    endfunction

    // With no stage engaged the request passes through against full range.
    function [`SGSC_ANA_W-1:0] sgsc_gmax;
        input [2:0] g;
        begin
            case (g)
                3'h1: sgsc_gmax = gear_stage_out_1_max_speed_in;
                3'h2: sgsc_gmax = gear_stage_out_2_max_speed_in;
                3'h3: sgsc_gmax = gear_stage_out_3_max_speed_in;
                3'h4: sgsc_gmax = gear_stage_out_4_max_speed_in;
                default: sgsc_gmax = `SGSC_ANA_MAX;
            endcase
        end
    endfunction

    // R19 scale by stage
    // Saturates at full scale once the request reaches the stage maximum; a zero maximum gives zero.
    function [`SGSC_ANA_W-1:0] sgsc_scale;
        input [`SGSC_ANA_W-1:0] req;
        input [`SGSC_ANA_W-1:0] gmax;
        reg [2*`SGSC_ANA_W-1:0] prod;
        reg [2*`SGSC_ANA_W-1:0] quo;
        begin
            prod = req * `SGSC_ANA_MAX;
            quo = {2*`SGSC_ANA_W{1'b0}};
            if (gmax == {`SGSC_ANA_W{1'b0}}) begin
                sgsc_scale = {`SGSC_ANA_W{1'b0}};
            end else if (req >= gmax) begin
                sgsc_scale = `SGSC_ANA_MAX;
            end else begin
                quo = prod / gmax;
                sgsc_scale = quo[`SGSC_ANA_W-1:0];
            end
        end
    endfunction

    wire [2:0] auto_pick = sgsc_pick(auto_sel);
    wire [2:0] sw_pick = sgsc_pick(sw_sel);

    // Millisecond tick prescaler keeps the delay counters narrow.
    // It runs free, so a delay of N ticks lasts N-1 to N ticks plus one cycle.
    always @(posedge clock_in) begin
        if (!resetn_in || tick) begin
            tick_cnt_r <= {`SGSC_TICK_W{1'b0}};
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end

    always @* begin
        state_nxt = state_r;
        gear_nxt = gear_r;
        target_nxt = target_r;
        time_cnt_nxt = time_cnt_r;
        ana_nxt = analog_speed_out;
        cur_nxt = current_gear_out;
        tmo_nxt = shift_timeout_alarm_out;
        dis_nxt = 1'b0;
        done_nxt = 1'b0;
        if (tick && !time_up) begin
            time_cnt_nxt = time_cnt_r - 1'b1;
        end
        // Commands that arrive while busy are dropped, not queued.
        case (state_r)
            `SGSC_ST_IDLE: begin
                // R10 mode select
                if (speed_control_select_in) begin
                    // A speed code in analog idle rescales against the stage now engaged.
                    if (speed_code_in && codes_ok) begin
                        ana_nxt = sgsc_scale(speed_request_in, sgsc_gmax(current_gear_out));
                    end
                    if (auto_pick != 3'h0 && codes_ok) begin
                        // R1 auto enable gate
                        // R8 analog mode only
                        if (!auto_shift_enable_in) begin
                            // R9 disabled select alarm
                            dis_nxt = 1'b1;
                        // R2 compare stage
                        end else if (auto_pick == current_gear_out) begin
                            // Same stage: report done at once and leave the outputs alone.
                            done_nxt = 1'b1;
                        end else begin
                            // R3 shift speed out
                            ana_nxt = shift_speed_value_in;
                            target_nxt = auto_pick;
                            // A new shift clears a time-out alarm left by the last one.
                            tmo_nxt = 1'b0;
                            time_cnt_nxt = shift_delay_one_in;
                            state_nxt = `SGSC_ST_DLY1;
                        end
                    end
                end else if (codes_ok) begin
                    if (switch_gear_cancel_cmd_in) begin
                        // R14 cancel all
                        // The gearbox is left where it is; the stage requests and the current gear record drop.
                        gear_nxt = 4'h0;
                        cur_nxt = 3'h0;
                        done_nxt = 1'b1;
                    end else if (sw_pick != 3'h0 || speed_code_in) begin
                        // R16 switching timing
                        // A speed code alone runs the same timing with no target, so no output moves.
                        target_nxt = sw_pick;
                        time_cnt_nxt = switch_gear_delay_in;
                        state_nxt = `SGSC_ST_SWDL;
                    end
                end
            end
            `SGSC_ST_DLY1: begin
                if (time_up) begin
                    // R4 swap outputs
                    // The old stage drops one cycle before the new one rises, so the
                    // gearbox never sees two stages requested at once.
                    if (gear_r != 4'h0) begin
                        gear_nxt = 4'h0;
                    end else begin
                        gear_nxt = sgsc_onehot(target_r);
                        time_cnt_nxt = shift_check_timeout_in;
                        state_nxt = `SGSC_ST_WAIT;
                    end
                end
            end
            `SGSC_ST_WAIT: begin
                // R5 wait in-position
                // The wait has no end of its own; only an in-position input leaves it.
                // R18 per-stage input
                if ((in_pos & sgsc_onehot(target_r)) != 4'h0) begin
                    cur_nxt = target_r;
                    time_cnt_nxt = shift_delay_two_in;
                    state_nxt = `SGSC_ST_DLY2;
                end else if (time_up) begin
                    // R6 timeout alarm
                    // The alarm does not abort the shift; a late in-position still completes it.
                    tmo_nxt = 1'b1;
                end
            end
            `SGSC_ST_DLY2: begin
                if (time_up) begin
                    // R7 final speed
                    ana_nxt = sgsc_scale(speed_request_in, sgsc_gmax(target_r));
                    // R17 hold output
                    // The current gear stays recorded even when the output is released.
                    if (!gear_output_hold_in) begin
                        gear_nxt = 4'h0;
                    end
                    done_nxt = 1'b1;
                    state_nxt = `SGSC_ST_IDLE;
                end
            end
            `SGSC_ST_SWDL: begin
                if (time_up) begin
                    if (target_r != 3'h0) begin
                        // R13 latch one output
                        gear_nxt = sgsc_onehot(target_r);
                        // R20 current gear update
                        cur_nxt = target_r;
                    end
                    time_cnt_nxt = speed_code_exec_time_in;
                    state_nxt = `SGSC_ST_SWEX;
                end
            end
            `SGSC_ST_SWEX: begin
                if (time_up) begin
                    done_nxt = 1'b1;
                    state_nxt = `SGSC_ST_IDLE;
                end
            end
            default: begin
                state_nxt = `SGSC_ST_IDLE;
            end
        endcase
    end

    always @(posedge clock_in) begin
        if (!resetn_in) begin
            state_r <= `SGSC_ST_IDLE;
            // R12 outputs idle at reset
            gear_r <= 4'h0;
            target_r <= 3'h0;
            time_cnt_r <= {`SGSC_TIME_W{1'b0}};
            analog_speed_out <= {`SGSC_ANA_W{1'b0}};
            current_gear_out <= 3'h0;
            shift_timeout_alarm_out <= 1'b0;
            shift_disabled_alarm_out <= 1'b0;
            speed_code_done_out <= 1'b0;
            shift_busy_out <= 1'b0;
            gear_stage_out_1 <= 1'b0;
            gear_stage_out_2 <= 1'b0;
            gear_stage_out_3 <= 1'b0;
            gear_stage_out_4 <= 1'b0;
        end else begin
            // Every port is loaded from its next value, so outputs come straight from flip-flops.
            state_r <= state_nxt;
            gear_r <= gear_nxt;
            target_r <= target_nxt;
            time_cnt_r <= time_cnt_nxt;
            analog_speed_out <= ana_nxt;
            current_gear_out <= cur_nxt;
            shift_timeout_alarm_out <= tmo_nxt;
            shift_disabled_alarm_out <= dis_nxt;
            speed_code_done_out <= done_nxt;
            // Busy follows the next state, so a command can be taken in the same cycle that done is high.
            shift_busy_out <= (state_nxt != `SGSC_ST_IDLE);
            gear_stage_out_1 <= gear_nxt[0];
            gear_stage_out_2 <= gear_nxt[1];
            gear_stage_out_3 <= gear_nxt[2];
            gear_stage_out_4 <= gear_nxt[3];
        end
    end

endmodule

// ### sim/sgsc_gear_stage_monitor.sv
/*
 Checker watching the ports of the gear stage sequencer.
 Assumes one clock domain and commands given as one-cycle pulses.
*/
`timescale 1ns/1ps
`include "sgsc_defs.vh"
module sgsc_gear_stage_monitor (
    input wire clock_in,
    input wire resetn_in,
    input wire auto_shift_enable_in,
    input wire speed_control_select_in,
    input wire estop_speed_code_block_in,
    input wire estop_in,
    input wire auto_gear_select_1_in,
    input wire auto_gear_select_2_in,
    input wire auto_gear_select_3_in,
    input wire auto_gear_select_4_in,
    input wire switch_gear_cmd_1_in,
    input wire switch_gear_cmd_2_in,
    input wire switch_gear_cmd_3_in,
    input wire switch_gear_cmd_4_in,
    input wire switch_gear_cancel_cmd_in,
    input wire [`SGSC_ANA_W-1:0] shift_speed_value_in,
    input wire gear_stage_out_1,
    input wire gear_stage_out_2,
    input wire gear_stage_out_3,
    input wire gear_stage_out_4,
    input wire [`SGSC_ANA_W-1:0] analog_speed_out,
    input wire [2:0] current_gear_out,
    input wire shift_busy_out,
    input wire shift_timeout_alarm_out,
    input wire shift_disabled_alarm_out,
    input wire speed_code_done_out
);
    wire [3:0] gears = {gear_stage_out_4, gear_stage_out_3, gear_stage_out_2, gear_stage_out_1};
    wire sel_any = auto_gear_select_1_in | auto_gear_select_2_in | auto_gear_select_3_in | auto_gear_select_4_in;
    wire sw_any = switch_gear_cmd_1_in | switch_gear_cmd_2_in | switch_gear_cmd_3_in | switch_gear_cmd_4_in;
    wire [2:0] req_gear = auto_gear_select_1_in ? 3'h1 : auto_gear_select_2_in ? 3'h2 :
                          auto_gear_select_3_in ? 3'h3 : 3'h4;
    wire take = !shift_busy_out && !(estop_in && estop_speed_code_block_in);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    sequence auto_take;
        take && speed_control_select_in && sel_any;
    endsequence
    onehot_gears_a: assert property ($onehot0(gears)) else $error("two gear outputs active");
    reset_idle_a: assert property ($rose(resetn_in) |-> gears == 4'h0 && current_gear_out == 3'h0)
        else $error("gear state not idle after reset");
    cancel_clear_a: assert property (take && !speed_control_select_in && switch_gear_cancel_cmd_in
        |=> gears == 4'h0 && speed_code_done_out) else $error("cancel left a gear output");
    shift_start_a: assert property (auto_take ##0 (auto_shift_enable_in && req_gear != current_gear_out)
        |=> shift_busy_out && analog_speed_out == shift_speed_value_in) else $error("shift start speed wrong");
    same_gear_a: assert property (auto_take ##0 (auto_shift_enable_in && req_gear == current_gear_out)
        |=> speed_code_done_out && !shift_busy_out) else $error("same gear started a shift");
    disabled_alarm_a: assert property (auto_take ##0 !auto_shift_enable_in
        |=> shift_disabled_alarm_out && !shift_busy_out) else $error("disabled select gave no alarm");
    analog_only_a: assert property (take && !speed_control_select_in && sel_any
        |=> !shift_busy_out && !shift_disabled_alarm_out) else $error("auto select ran in switching mode");
    estop_block_a: assert property (!shift_busy_out && estop_in && estop_speed_code_block_in && (sel_any || sw_any)
        |=> !shift_busy_out && !speed_code_done_out) else $error("command ran during blocked stop");
    alarm_cause_a: assert property ($rose(shift_timeout_alarm_out) |-> $past(shift_busy_out))
        else $error("time-out alarm outside a shift");
    gear_update_a: assert property ($changed(current_gear_out) && current_gear_out != 3'h0
        |-> $past(shift_busy_out)) else $error("current gear changed without a shift");
endmodule
bind sgsc_gear_stage_ctrl sgsc_gear_stage_monitor i_mon (.clock_in, .resetn_in, .auto_shift_enable_in,
    .speed_control_select_in, .estop_speed_code_block_in, .estop_in, .auto_gear_select_1_in,
    .auto_gear_select_2_in, .auto_gear_select_3_in, .auto_gear_select_4_in, .switch_gear_cmd_1_in,
    .switch_gear_cmd_2_in, .switch_gear_cmd_3_in, .switch_gear_cmd_4_in, .switch_gear_cancel_cmd_in,
    .shift_speed_value_in, .gear_stage_out_1, .gear_stage_out_2, .gear_stage_out_3, .gear_stage_out_4,
    .analog_speed_out, .current_gear_out, .shift_busy_out, .shift_timeout_alarm_out,
    .shift_disabled_alarm_out, .speed_code_done_out);

// ### sim/sgsc_gearbox_model.sv
/*
 Gearbox model: a stage reports in position some cycles after its gear output.
 Assumes at most one gear output high; stuck_in holds engagement back.
*/
`timescale 1ns/1ps
module sgsc_gearbox_model #(
    parameter integer ENGAGE_CYCLES = 5
) (
    input wire clock_in,
    input wire [3:0] gear_cmd_in,
    input wire stuck_in,
    output reg [3:0] in_position_out
);
    integer cnt = 0;
    reg [3:0] eng = 4'h0;
    initial in_position_out = 4'h0;
    always @(posedge clock_in) begin
        if (gear_cmd_in != 4'h0 && gear_cmd_in != eng) begin
            eng <= gear_cmd_in;
            cnt <= 0;
            in_position_out <= 4'h0;
        end else if (!stuck_in && eng != 4'h0) begin
            if (cnt == ENGAGE_CYCLES) in_position_out <= eng;
            else cnt <= cnt + 1;
        end
    end
endmodule

// ### sim/tb_spindle_gear_stage_control.sv
/*
 Self-checking bench for the gear stage sequencer with a gearbox model.
 Assumes the monitor binds itself; millisecond ticks shortened to TICK cycles.
*/
`timescale 1ns/1ps
module tb_spindle_gear_stage_control;
    localparam integer TICK = 4;
    reg clock_in, resetn_in, enable, hold, mode, block, estop, scode, stuck, cancel;
    reg [3:0] asel, scmd;
    reg [11:0] req;
    reg [11:0] sspd, gm1, gm2, gm3, gm4;
    reg [15:0] t_chk;
    wire [3:0] gears, inpos;
    wire [11:0] analog;
    wire [2:0] cur;
    wire busy, t_alarm, d_alarm, done;
    integer error_cnt, n_checks, cyc;
    sgsc_gear_stage_ctrl #(.TICK_CYCLES(TICK)) i_dut (.clock_in(clock_in), .resetn_in(resetn_in),
        .auto_shift_enable_in(enable), .gear_output_hold_in(hold), .speed_control_select_in(mode),
        .estop_speed_code_block_in(block), .estop_in(estop), .auto_gear_select_1_in(asel[0]),
        .auto_gear_select_2_in(asel[1]), .auto_gear_select_3_in(asel[2]), .auto_gear_select_4_in(asel[3]),
        .switch_gear_cmd_1_in(scmd[0]), .switch_gear_cmd_2_in(scmd[1]), .switch_gear_cmd_3_in(scmd[2]),
        .switch_gear_cmd_4_in(scmd[3]), .switch_gear_cancel_cmd_in(cancel), .speed_code_in(scode),
        .speed_request_in(req), .gear_in_position_1_in(inpos[0]), .gear_in_position_2_in(inpos[1]),
        .gear_in_position_3_in(inpos[2]), .gear_in_position_4_in(inpos[3]), .shift_speed_value_in(sspd),
        .shift_delay_one_in(16'h0002), .shift_delay_two_in(16'h0002), .shift_check_timeout_in(t_chk),
        .speed_code_exec_time_in(16'h0002), .switch_gear_delay_in(16'h0002), .gear_stage_out_1_max_speed_in(gm1),
        .gear_stage_out_2_max_speed_in(gm2), .gear_stage_out_3_max_speed_in(gm3), .gear_stage_out_4_max_speed_in(gm4),
        .gear_stage_out_1(gears[0]), .gear_stage_out_2(gears[1]), .gear_stage_out_3(gears[2]),
        .gear_stage_out_4(gears[3]), .analog_speed_out(analog), .current_gear_out(cur), .shift_busy_out(busy),
        .shift_timeout_alarm_out(t_alarm), .shift_disabled_alarm_out(d_alarm), .speed_code_done_out(done));
    sgsc_gearbox_model i_box (.clock_in(clock_in), .gear_cmd_in(gears), .stuck_in(stuck), .in_position_out(inpos));
    function [15:0] exp_speed(input integer r, input integer m);
        exp_speed = (r * 4095 / m > 4095) ? 16'hfff : r * 4095 / m;
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    // Lets one falling edge pass first, so back-to-back calls keep a clock edge between commands.
    // Holds one command for a single cycle and returns just after the edge that took it.
    task go(input [3:0] a, input [3:0] s, input c, input sc);
        begin
            @(negedge clock_in);
            asel = a;
            scmd = s;
            cancel = c;
            scode = sc;
            @(negedge clock_in);
            {asel, scmd, cancel, scode} = 10'h000;
        end
    endtask
    task wait_on(input alarm);
        begin
            cyc = 0;
            while ((alarm ? t_alarm : done) !== 1'b1) begin
                @(negedge clock_in);
                cyc = cyc + 1;
                if (cyc > 500) begin
                    error_cnt = error_cnt + 1;
                    report_and_stop;
                end
            end
        end
    endtask
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    initial begin
        {error_cnt, n_checks, cyc} = 0;
        {resetn_in, enable, hold, mode, block, estop, scode, stuck, cancel, asel, scmd} = 0;
        req = 12'h600;
        {sspd, gm1, gm2, gm3, gm4} = {12'h123, 12'h400, 12'h800, 12'hc00, 12'ha00};
        t_chk = 16'h0003;
        repeat (6) @(negedge clock_in);
        resetn_in = 1'b1;
        @(negedge clock_in);
        chk({gears, 1'b0, cur}, 16'h00);
        go(4'h0, 4'h4, 1'b0, 1'b0);
        wait_on(1'b0);
        chk(cyc >= TICK && cyc <= 4 * TICK + 4, 16'h1);
        chk({gears, 1'b0, cur}, 16'h43);
        go(4'h0, 4'h1, 1'b0, 1'b0);
        wait_on(1'b0);
        chk({gears, 1'b0, cur}, 16'h11);
        go(4'h0, 4'h0, 1'b0, 1'b1);
        wait_on(1'b0);
        chk({gears, 1'b0, cur}, 16'h11);
        go(4'h2, 4'h0, 1'b0, 1'b0);
        chk({busy, d_alarm}, 16'h0);
        chk(cur, 16'h1);
        {estop, block} = 2'b11;
        go(4'h0, 4'h2, 1'b0, 1'b0);
        chk({busy, gears}, 16'h01);
        block = 1'b0;
        go(4'h0, 4'h2, 1'b0, 1'b0);
        wait_on(1'b0);
        chk({gears, 1'b0, cur}, 16'h22);
        estop = 1'b0;
        go(4'h0, 4'h0, 1'b1, 1'b0);
        chk({done, gears}, 16'h10);
        mode = 1'b1;
        go(4'h0, 4'h1, 1'b0, 1'b0);
        chk({busy, gears}, 16'h00);
        go(4'h4, 4'h0, 1'b0, 1'b0);
        chk({d_alarm, busy}, 16'h2);
        chk(analog, 16'h000);
        {enable, hold} = 2'b11;
        go(4'h4, 4'h0, 1'b0, 1'b0);
        chk(analog, 16'h123);
        wait_on(1'b0);
        chk({gears, 1'b0, cur}, 16'h43);
        chk(analog, exp_speed(req, 12'hc00));
        go(4'h4, 4'h0, 1'b0, 1'b0);
        chk({done, busy}, 16'h2);
        {stuck, sspd} = {1'b1, 12'h2a5};
        go(4'h1, 4'h0, 1'b0, 1'b0);
        chk(analog, 16'h2a5);
        wait_on(1'b1);
        chk(t_alarm, 16'h1);
        chk(cyc >= 2 * TICK && cyc <= 5 * TICK + 6, 16'h1);
        chk({busy, gears, 1'b0, cur}, 16'h113);
        stuck = 1'b0;
        wait_on(1'b0);
        chk({gears, 1'b0, cur}, 16'h11);
        {hold, req} = {1'b0, 12'h500};
        go(4'h8, 4'h0, 1'b0, 1'b0);
        chk({t_alarm, busy}, 16'h1);
        wait_on(1'b0);
        chk({gears, 1'b0, cur}, 16'h04);
        chk(analog, exp_speed(req, 12'ha00));
        req = 12'h300;
        go(4'h0, 4'h0, 1'b0, 1'b1);
        chk(analog, exp_speed(req, gm4));
        req = 12'hc00;
        go(4'h0, 4'h0, 1'b0, 1'b1);
        chk(analog, exp_speed(req, gm4));
        resetn_in = 1'b0;
        repeat (2) @(negedge clock_in);
        resetn_in = 1'b1;
        @(negedge clock_in);
        chk({analog, 1'b0, cur}, 16'h0000);
        report_and_stop;
    end
endmodule
